// ===== common/shw_consts.svh
// Register indices, field positions, reset values, highway lengths minus one and bit numbers
`ifndef SHW_CONSTS_SVH
`define SHW_CONSTS_SVH
`define SHW_IDX_GLOBAL_MODE 6'h06
`define SHW_IDX_TX_OFFSET 6'h17
`define SHW_IDX_RX_OFFSET 6'h18
`define SHW_IDX_RX_CTRL0 6'h20
`define SHW_IDX_RX_CTRL3 6'h23
`define SHW_IDX_STATUS 6'h24
`define SHW_MODE_UPPER_BIT 2
`define SHW_MODE_LOWER_BIT 1
`define SHW_RX_SRC_BIT 5
`define SHW_RX_SLIP_BIT 3
`define SHW_RST_BYTE 8'h00
`define SHW_RST_WORD 32'h00000000
`define SHW_LEN_2M_M1 15'h00ff
`define SHW_LEN_8M_M1 15'h03ff
`define SHW_LEN_16M_M1 15'h7fff
`define SHW_BIT_FIRST 3'h0
`define SHW_BIT_LAST 3'h7
`endif

// ===== common/shw_pkg.sv
// Types shared by the system highway port
package shw_pkg;
  typedef enum logic [3:0] {
    SHW_OFF = 4'b0001,
    SHW_M2 = 4'b0010,
    SHW_M8 = 4'b0100,
    SHW_M16 = 4'b1000
  } shw_mode_t;
  typedef enum logic [1:0] {
    SHW_BUS_IDLE = 2'b01,
    SHW_BUS_ACK = 2'b10
  } shw_bus_state_t;
  typedef struct packed {
    logic [7:0] data;
    logic [7:0] sig;
  } shw_slot_t;
  typedef struct packed {
    logic upper;
    logic lower;
    logic [7:0] tx_off;
    logic [7:0] rx_off;
    logic [3:0] rx_src;
    logic [3:0] rx_slip;
  } shw_cfg_t;
endpackage

// ===== verilog/shw_highway_port.sv
// System highway port: register slave, mode decode, receive and transmit highway framing
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
`include "shw_consts.svh"
// Summary of operation
// - With the family pin low and both mode bits 0 the port runs one 2 Mbit/s highway per framer.
// - With the family pin low, upper mode bit 1 and lower bit 0 all framers share one 8 Mbit/s highway.
// - With the family pin low, upper mode bit 0 and lower bit 1 all framers share one 16 Mbit/s highway.
// - Clock source 0 with slip buffer enabled makes receive timing follow the external sync pulse.
// - Bit 5 of each framer's receive control register picks the clock source and bit 3 enables the slip buffer.
// - In 8 Mbit/s mode the framers' slots are byte-interleaved on the shared data and signaling lines.
// - In 16 Mbit/s mode the framers' data and signaling slots are bit-interleaved on the shared line.
// - In 16 Mbit/s mode the highway multiframe covers 16 frames, 2 ms.
// - Receive timing is shifted from the receive sync pulse by the receive sync offset.
// - Transmit timing is shifted from the transmit sync pulse by the transmit sync offset.
// - Receive data leaves on the falling highway clock edge and receive sync is sampled on the rising edge.
// - Transmit data, signaling and sync are sampled on the rising highway clock edge.
// - Clock source 1 makes the port drive its own receive sync pulse from internal timing, on every pin in 2 Mbit/s mode and on pin 0 only in 8 and 16 Mbit/s modes.
module shw_highway_port (
  input wire logic clk,
  input wire logic rst,
  input wire logic hwy_clk,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic highway_family_select_pin,
  input wire logic [3:0] rx_hwy_sync_per_port_in,
  output logic [3:0] rx_hwy_sync_per_port_out,
  output logic [3:0] rx_hwy_sync_per_port_oe,
  output logic [3:0] rx_hwy_data_per_port,
  output logic [3:0] rx_hwy_signaling_per_port,
  input wire logic [3:0] tx_hwy_sync_per_port,
  input wire logic [3:0] tx_hwy_data_per_port,
  input wire logic [3:0] tx_hwy_signaling_per_port,
  input wire shw_pkg::shw_slot_t [3:0] rx_fr_byte,
  output logic [3:0] rx_fr_take,
  output logic [3:0][4:0] rx_fr_slot,
  output shw_pkg::shw_slot_t [3:0] tx_fr_byte,
  output logic [3:0] tx_fr_valid,
  output logic [3:0][4:0] tx_fr_slot
);
  shw_pkg::shw_bus_state_t bus_st;
  logic [5:0] idx;
  logic [7:0] gmode;
  logic [7:0] tx_off;
  logic [7:0] rx_off;
  logic [3:0][7:0] rx_ctrl;
  logic [31:0] rd_val;
  shw_pkg::shw_cfg_t cfg_c;
  shw_pkg::shw_cfg_t cfg_m;
  shw_pkg::shw_cfg_t cfg_s;
  logic [4:0] st_m;
  logic [4:0] st_s;
  logic lrst_m;
  logic lrst;
  logic [2:0] pin_q;
  logic fam_pin;
  shw_pkg::shw_mode_t mode;
  logic [14:0] len_m1;
  logic [3:0][14:0] rpos;
  logic [3:0][14:0] tpos;
  logic [3:0][14:0] rstart;
  logic [3:0][14:0] tstart;
  logic [3:0] rsync_q;
  logic [3:0] tsync_q;
  logic [3:0] r_evt;
  logic [3:0] t_evt;
  logic [3:0] r_act;
  logic [3:0] nb_d;
  logic [3:0] nb_s;
  logic [3:0] so_c;
  logic [3:0] oe_c;
  logic [3:0] next_rd;
  logic [3:0] next_rs;

  // Register slave: one wait cycle, then the access completes
  assign idx = avs_address[7:2];

  always_comb begin
    rd_val = `SHW_RST_WORD;
    case (idx)
      `SHW_IDX_GLOBAL_MODE: rd_val = {24'h000000, gmode};
      `SHW_IDX_TX_OFFSET: rd_val = {24'h000000, tx_off};
      `SHW_IDX_RX_OFFSET: rd_val = {24'h000000, rx_off};
      `SHW_IDX_STATUS: rd_val = {27'h0000000, st_s};
      default: begin
        if (idx >= `SHW_IDX_RX_CTRL0 && idx <= `SHW_IDX_RX_CTRL3) begin
          rd_val = {24'h000000, rx_ctrl[idx[1:0]]};
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_st <= shw_pkg::SHW_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= `SHW_RST_WORD;
    end else begin
      case (bus_st)
        shw_pkg::SHW_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_st <= shw_pkg::SHW_BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_val : `SHW_RST_WORD;
          end
        end
        shw_pkg::SHW_BUS_ACK: begin
          bus_st <= shw_pkg::SHW_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_st <= shw_pkg::SHW_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gmode <= `SHW_RST_BYTE;
      tx_off <= `SHW_RST_BYTE;
      rx_off <= `SHW_RST_BYTE;
      rx_ctrl <= {4{`SHW_RST_BYTE}};
    end else if (bus_st == shw_pkg::SHW_BUS_ACK && avs_write && avs_byteenable[0]) begin
      case (idx)
        `SHW_IDX_GLOBAL_MODE: gmode <= avs_writedata[7:0];
        `SHW_IDX_TX_OFFSET: tx_off <= avs_writedata[7:0];
        `SHW_IDX_RX_OFFSET: rx_off <= avs_writedata[7:0];
        default: begin
          if (idx >= `SHW_IDX_RX_CTRL0 && idx <= `SHW_IDX_RX_CTRL3) begin
            rx_ctrl[idx[1:0]] <= avs_writedata[7:0];
          end
        end
      endcase
    end
  end

  // Configuration is quasi-static; software changes it only while the highway is idle
  always_comb begin
    cfg_c.upper = gmode[`SHW_MODE_UPPER_BIT];
    cfg_c.lower = gmode[`SHW_MODE_LOWER_BIT];
    cfg_c.tx_off = tx_off;
    cfg_c.rx_off = rx_off;
    for (int i = 0; i < 4; i++) begin
      cfg_c.rx_src[i] = rx_ctrl[i][`SHW_RX_SRC_BIT];
      cfg_c.rx_slip[i] = rx_ctrl[i][`SHW_RX_SLIP_BIT];
    end
  end

  always_ff @(posedge hwy_clk) begin
    cfg_m <= cfg_c;
    cfg_s <= cfg_m;
    lrst_m <= rst;
    lrst <= lrst_m;
  end

  // Status back to the register side: decoded mode and family pin
  always_ff @(posedge clk) begin
    st_m <= {fam_pin, mode};
    st_s <= st_m;
  end

  // Family pin: three flops, a change counts once the last two agree
  always_ff @(posedge hwy_clk) begin
    if (lrst) begin
      pin_q <= 3'h0;
      fam_pin <= 1'b0;
    end else begin
      pin_q <= {pin_q[1:0], highway_family_select_pin};
      if (pin_q[1] == pin_q[2]) begin
        fam_pin <= pin_q[2];
      end
    end
  end

  // Pin high selects the bus-compatible family, which this port does not carry
  always_comb begin
    mode = shw_pkg::SHW_OFF;
    len_m1 = `SHW_LEN_2M_M1;
    if (!lrst && !fam_pin) begin
      case ({cfg_s.upper, cfg_s.lower})
        2'b00: mode = shw_pkg::SHW_M2;
        2'b10: begin
          mode = shw_pkg::SHW_M8;
          len_m1 = `SHW_LEN_8M_M1;
        end
        2'b01: begin
          mode = shw_pkg::SHW_M16;
          len_m1 = `SHW_LEN_16M_M1;
        end
        default: mode = shw_pkg::SHW_OFF;
      endcase
    end
  end

  for (genvar f = 0; f < 4; f++) begin : g_fr
    logic [14:0] rp;
    logic [14:0] tp;
    logic [7:0] rsh_d;
    logic [7:0] rsh_s;
    logic [7:0] tsh_d;
    logic [7:0] tsh_s;
    logic [7:0] next_tsh_d;
    logic [7:0] next_tsh_s;
    logic ld;
    logic shd;
    logic shs;
    logic tk_d;
    logic tk_s;
    logic last;
    logic bd;
    logic bs;
    logic [4:0] rslot;
    logic [4:0] tslot;

    assign rp = (mode == shw_pkg::SHW_M2) ? rpos[f] : rpos[0];
    assign tp = (mode == shw_pkg::SHW_M2) ? tpos[f] : tpos[0];
    // Sync pins are sampled on the rising highway clock edge; only the rising edge of the pulse counts
    assign r_evt[f] = rx_hwy_sync_per_port_in[f] & ~rsync_q[f] & ~cfg_s.rx_src[f] & cfg_s.rx_slip[f];
    assign t_evt[f] = tx_hwy_sync_per_port[f] & ~tsync_q[f];
    assign rstart[f] = (len_m1 + 15'h0001 - {7'h00, cfg_s.rx_off}) & len_m1;
    assign tstart[f] = (len_m1 + 15'h0001 - {7'h00, cfg_s.tx_off}) & len_m1;
    assign r_act[f] = (mode != shw_pkg::SHW_OFF) & (cfg_s.rx_src[f] | cfg_s.rx_slip[f]);
    assign nb_d[f] = ld ? rx_fr_byte[f].data[7] : rsh_d[7];
    assign nb_s[f] = ld ? rx_fr_byte[f].sig[7] : rsh_s[7];
    assign so_c[f] = cfg_s.rx_src[f] & (rp == rstart[f]);
    assign oe_c[f] = cfg_s.rx_src[f] & (mode == shw_pkg::SHW_M2 || (f == 0 && mode != shw_pkg::SHW_OFF));

    always_comb begin
      ld = 1'b0;
      shd = 1'b0;
      shs = 1'b0;
      tk_d = 1'b0;
      tk_s = 1'b0;
      last = 1'b0;
      bd = tx_hwy_data_per_port[0];
      bs = tx_hwy_signaling_per_port[0];
      rslot = rp[9:5];
      tslot = tp[9:5];
      case (mode)
        shw_pkg::SHW_M2: begin
          ld = rp[2:0] == `SHW_BIT_FIRST;
          shd = 1'b1;
          shs = 1'b1;
          tk_d = 1'b1;
          tk_s = 1'b1;
          last = tp[2:0] == `SHW_BIT_LAST;
          bd = tx_hwy_data_per_port[f];
          bs = tx_hwy_signaling_per_port[f];
          rslot = rp[7:3];
          tslot = tp[7:3];
        end
        shw_pkg::SHW_M8: begin
          ld = rp[4:3] == 2'(f) && rp[2:0] == `SHW_BIT_FIRST;
          shd = rp[4:3] == 2'(f);
          shs = shd;
          tk_d = tp[4:3] == 2'(f);
          tk_s = tk_d;
          last = tk_d && tp[2:0] == `SHW_BIT_LAST;
        end
        shw_pkg::SHW_M16: begin
          ld = rp[5:0] == 6'h00;
          shd = rp[2:0] == 3'(2 * f);
          shs = rp[2:0] == 3'(2 * f + 1);
          tk_d = tp[2:0] == 3'(2 * f);
          tk_s = tp[2:0] == 3'(2 * f + 1);
          last = tk_s && tp[5:3] == `SHW_BIT_LAST;
          bs = tx_hwy_data_per_port[0];
          rslot = rp[10:6];
          tslot = tp[10:6];
        end
        default: begin
          ld = 1'b0;
        end
      endcase
      next_tsh_d = tk_d ? {tsh_d[6:0], bd} : tsh_d;
      next_tsh_s = tk_s ? {tsh_s[6:0], bs} : tsh_s;
    end

    always_ff @(posedge hwy_clk) begin
      if (lrst) begin
        rpos[f] <= 15'h0000;
        rsync_q[f] <= 1'b0;
      end else begin
        rsync_q[f] <= rx_hwy_sync_per_port_in[f];
        if (r_evt[f]) begin
          rpos[f] <= rstart[f];
        end else begin
          rpos[f] <= (rpos[f] + 15'h0001) & len_m1;
        end
      end
    end

    always_ff @(posedge hwy_clk) begin
      if (lrst) begin
        rsh_d <= `SHW_RST_BYTE;
        rsh_s <= `SHW_RST_BYTE;
        rx_fr_take[f] <= 1'b0;
        rx_fr_slot[f] <= 5'h00;
      end else begin
        if (ld) begin
          rsh_d <= shd ? {rx_fr_byte[f].data[6:0], 1'b0} : rx_fr_byte[f].data;
          rsh_s <= shs ? {rx_fr_byte[f].sig[6:0], 1'b0} : rx_fr_byte[f].sig;
        end else begin
          rsh_d <= shd ? {rsh_d[6:0], 1'b0} : rsh_d;
          rsh_s <= shs ? {rsh_s[6:0], 1'b0} : rsh_s;
        end
        rx_fr_take[f] <= ld & r_act[f];
        rx_fr_slot[f] <= rslot;
      end
    end

    always_ff @(posedge hwy_clk) begin
      if (lrst) begin
        tpos[f] <= 15'h0000;
        tsync_q[f] <= 1'b0;
        tsh_d <= `SHW_RST_BYTE;
        tsh_s <= `SHW_RST_BYTE;
        tx_fr_byte[f] <= '0;
        tx_fr_valid[f] <= 1'b0;
        tx_fr_slot[f] <= 5'h00;
      end else begin
        tsync_q[f] <= tx_hwy_sync_per_port[f];
        if (t_evt[f]) begin
          tpos[f] <= tstart[f];
        end else begin
          tpos[f] <= (tpos[f] + 15'h0001) & len_m1;
        end
        tsh_d <= next_tsh_d;
        tsh_s <= next_tsh_s;
        tx_fr_valid[f] <= last;
        if (last) begin
          tx_fr_byte[f] <= {next_tsh_d, next_tsh_s};
          tx_fr_slot[f] <= tslot;
        end
      end
    end
  end

  // Line multiplexer; idle or inactive lines sit at 1
  always_comb begin
    next_rd = 4'hf;
    next_rs = 4'hf;
    case (mode)
      shw_pkg::SHW_M2: begin
        next_rd = nb_d | ~r_act;
        next_rs = nb_s | ~r_act;
      end
      shw_pkg::SHW_M8: begin
        next_rd = {3'h7, nb_d[rpos[0][4:3]] | ~r_act[0]};
        next_rs = {3'h7, nb_s[rpos[0][4:3]] | ~r_act[0]};
      end
      shw_pkg::SHW_M16: begin
        next_rd = {3'h7, (rpos[0][0] ? nb_s[rpos[0][2:1]] : nb_d[rpos[0][2:1]]) | ~r_act[0]};
      end
      default: begin
        next_rd = 4'hf;
      end
    endcase
  end

  always_ff @(negedge hwy_clk) begin
    if (lrst) begin
      rx_hwy_data_per_port <= 4'hf;
      rx_hwy_signaling_per_port <= 4'hf;
      rx_hwy_sync_per_port_out <= 4'h0;
      rx_hwy_sync_per_port_oe <= 4'h0;
    end else begin
      rx_hwy_data_per_port <= next_rd;
      rx_hwy_signaling_per_port <= next_rs;
      rx_hwy_sync_per_port_out <= so_c & oe_c;
      rx_hwy_sync_per_port_oe <= oe_c;
    end
  end

  mode_2m_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    (!fam_pin && !cfg_s.upper && !cfg_s.lower) |-> mode == shw_pkg::SHW_M2)
    else $error("2M mode not selected");
  mode_8m_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    (!fam_pin && cfg_s.upper && !cfg_s.lower) |-> len_m1 == 15'h03ff && mode == shw_pkg::SHW_M8)
    else $error("8M mode not selected");
  mode_16m_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    (!fam_pin && !cfg_s.upper && cfg_s.lower) |-> mode == shw_pkg::SHW_M16)
    else $error("16M mode not selected");
  rx_sync_align_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    r_evt[0] |=> rpos[0] == $past(rstart[0]))
    else $error("rx position not aligned to sync");
  ctrl_field_a: assert property (@(posedge clk) disable iff (rst)
    (bus_st == shw_pkg::SHW_BUS_ACK && avs_write && avs_byteenable[0] && idx == `SHW_IDX_RX_CTRL0)
    |=> rx_ctrl[0][5] == $past(avs_writedata[5]) && rx_ctrl[0][3] == $past(avs_writedata[3]))
    else $error("rx control fields not stored");
  byte_order_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    (mode == shw_pkg::SHW_M8 && r_act[1]) ##1 rx_fr_take[1] |-> $past(rpos[0][4:0]) == 5'h08)
    else $error("8M framer order wrong");
  bit_order_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    (mode == shw_pkg::SHW_M16 && !t_evt[0]) ##1 tx_fr_valid[2] |-> $past(tpos[0][5:0]) == 6'h3d)
    else $error("16M framer order wrong");
  mframe_wrap_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    (mode == shw_pkg::SHW_M16 && rpos[0] == 15'h7fff && !r_evt[0]) |=> rpos[0] == 15'h0000)
    else $error("16M multiframe length wrong");
  rx_offset_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    (r_evt[0] && cfg_s.rx_off == 8'h00) |=> rpos[0] == 15'h0000 ##1 rpos[0] == 15'h0001)
    else $error("rx offset misapplied");
  // Offset positions before the sync slot must wrap the counter to slot 0
  tx_offset_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    t_evt[0] |=> ((tpos[0] + {7'h00, $past(cfg_s.tx_off)}) & $past(len_m1)) == 15'h0000)
    else $error("tx offset misapplied");
  // The falling edge inside a cycle takes the value the mux shows in that same cycle
  rx_launch_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    (mode == shw_pkg::SHW_M2 && $stable(mode)) |-> rx_hwy_data_per_port[0] == next_rd[0])
    else $error("rx data not launched on falling edge");
  int_sync_a: assert property (@(posedge hwy_clk) disable iff (lrst)
    (cfg_s.rx_src[0] && mode == shw_pkg::SHW_M2) [*2] |-> rx_hwy_sync_per_port_oe[0])
    else $error("internal sync not driven");
  bus_answer_a: assert property (@(posedge clk) disable iff (rst)
    (bus_st == shw_pkg::SHW_BUS_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer timing wrong");

  take_8m_c: cover property (@(posedge hwy_clk) disable iff (lrst) mode == shw_pkg::SHW_M8 && rx_fr_take[3]);
  valid_16m_c: cover property (@(posedge hwy_clk) disable iff (lrst) mode == shw_pkg::SHW_M16 && tx_fr_valid[0]);
  ext_sync_c: cover property (@(posedge hwy_clk) disable iff (lrst) r_evt[0] && cfg_s.rx_off != 8'h00);
  int_sync_c: cover property (@(posedge hwy_clk) disable iff (lrst) rx_hwy_sync_per_port_out[0]);
endmodule

// ===== tb/shw_far_model.sv
// Far-side highway model: sync pulses and serial transmit streams
`timescale 1ns/1ps
module shw_far_model (
  input wire logic hwy_clk,
  input wire logic go,
  input wire logic [1:0] width,
  input wire logic [7:0] lag,
  input wire logic [3:0][63:0] st_d,
  input wire logic [3:0][63:0] st_s,
  output logic sync,
  output logic [3:0] tx_d,
  output logic [3:0] tx_s
);
  int k = -1;
  int i;
  initial begin
    sync = 1'b0;
    tx_d = 4'h0;
    tx_s = 4'h0;
  end
  // Drive on the falling edge so every line is settled at the rising edge
  always @(negedge hwy_clk) begin
    k = !go ? -1 : k + 1;
    i = k - 1 - int'(lag);
    sync <= k >= 0 && k < int'(width);
    for (int p = 0; p < 4; p++) begin
      // Outside the stream the lines toggle rather than hold a stale bit
      tx_d[p] <= (i >= 0 && i < 64) ? st_d[p][63 - i] : ~tx_d[p];
      tx_s[p] <= (i >= 0 && i < 64) ? st_s[p][63 - i] : ~tx_s[p];
    end
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the system highway port
`timescale 1ns/1ps
`include "shw_consts.svh"
module testbench;
  logic clk = 1'b0;
  logic hwy_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] be = 4'h0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic wait_req;
  logic pin = 1'b0;
  logic [3:0] so, soe, rxd, rxs, txd, txs, take, txv, sync_w;
  logic [3:0][4:0] rslot, tslot;
  shw_pkg::shw_slot_t [3:0] rbyte = 64'h9e37_4c1b_d2a6_5f08;
  shw_pkg::shw_slot_t [3:0] tbyte, lat;
  logic go = 1'b0;
  logic sync;
  logic [1:0] width = 2'h1;
  logic [7:0] lag = 8'h00;
  logic [3:0][63:0] sd, ss;
  logic [15:0] lfsr = 16'h002d;
  logic [15:0] lf2 = 16'h002d;
  logic [7:0] mv [3] = '{8'h00, 8'h04, 8'h02};
  logic [3:0] ms [3] = '{4'h2, 4'h4, 4'h8};
  logic [5:0] rg [7] = '{6'h06, 6'h17, 6'h18, 6'h20, 6'h21, 6'h22, 6'h23};
  int n_errors = 0;
  int n_compared = 0;

  always #25 clk = ~clk;
  always #40 hwy_clk = ~hwy_clk;
  // The port drives a receive sync pin only while its enable is up
  assign sync_w = (soe & so) | (~soe & {4{sync}});

  shw_highway_port dut_u (
    .clk(clk), .rst(rst), .hwy_clk(hwy_clk), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wait_req),
    .highway_family_select_pin(pin), .rx_hwy_sync_per_port_in(sync_w), .rx_hwy_sync_per_port_out(so),
    .rx_hwy_sync_per_port_oe(soe), .rx_hwy_data_per_port(rxd), .rx_hwy_signaling_per_port(rxs),
    .tx_hwy_sync_per_port({4{sync}}), .tx_hwy_data_per_port(txd), .tx_hwy_signaling_per_port(txs),
    .rx_fr_byte(rbyte), .rx_fr_take(take), .rx_fr_slot(rslot), .tx_fr_byte(tbyte), .tx_fr_valid(txv),
    .tx_fr_slot(tslot)
  );
  shw_far_model far_u (
    .hwy_clk(hwy_clk), .go(go), .width(width), .lag(lag), .st_d(sd), .st_s(ss), .sync(sync),
    .tx_d(txd), .tx_s(txs)
  );

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic rnd(output logic [7:0] r);
    lfsr = nxt(lfsr);
    r = lfsr[7:0];
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] b);
    int t;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {d, d, d, d};
    be <= b;
    rd <= ~w;
    wr <= w;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (wait_req !== 1'b0 && t < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (t >= 50) begin
      chk(0, 1, "bus timeout");
      wrap_up;
    end
  endtask
  task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1);
  endtask
  task automatic rchk(input logic [5:0] idx, input logic [31:0] e);
    bus(1'b0, idx, 8'h00, 4'hf);
    chk(q, e, "register read");
  endtask
  // Line position to framer, signaling flag and bit number
  task automatic map(input int m, input int i, output int f, output int s, output int b);
    f = m == 1 ? i / 8 : m == 2 ? (i % 8) / 2 : 0;
    s = m == 2 ? i % 2 : 0;
    b = m == 2 ? 7 - i / 8 : 7 - i % 8;
  endtask

  // One framed pass: sync from the far side, then the first slot of every framer
  task automatic run(input int m, input int ro);
    int L, n, f, s, b, i;
    logic [3:0] rseen = '0;
    logic [3:0] tseen = '0;
    logic [3:0] tk = '0;
    logic [3:0][63:0] gd = '0;
    logic [3:0][63:0] gs = '0;
    logic [3:0][63:0] ed = '0;
    logic [3:0][63:0] es = '0;
    shw_pkg::shw_slot_t [3:0] ex = '0;
    L = m == 0 ? 8 : m == 1 ? 32 : 64;
    for (int p = 0; p < 4; p++) begin
      for (int j = 0; j < L; j++) begin
        map(m, j, f, s, b);
        if (m == 0) begin
          ex[p].data[b] = sd[p][63 - j];
          ex[p].sig[b] = ss[p][63 - j];
        end else if (p == 0) begin
          if (s == 1)
            ex[f].sig[b] = sd[0][63 - j];
          else
            ex[f].data[b] = sd[0][63 - j];
          if (m == 1)
            ex[f].sig[b] = ss[0][63 - j];
        end
      end
    end
    @(posedge hwy_clk);
    go <= 1'b1;
    n = 0;
    do begin
      @(posedge hwy_clk);
      n++;
    end while (sync !== 1'b1 && n < 20);
    chk(n < 20, 1, "sync start");
    for (int k = 1; k < L + ro + 24; k++) begin
      @(posedge hwy_clk);
      i = k - 1 - ro;
      for (int p = 0; p < 4; p++) begin
        if (i >= 0 && i < L) begin
          gd[p][i] = rxd[p];
          gs[p][i] = rxs[p];
        end
        tk[p] = tk[p] | take[p];
        if (take[p] === 1'b1 && rslot[p] === 5'h00 && !rseen[p]) begin
          lat[p] = rbyte[p];
          rseen[p] = 1'b1;
        end
        if (txv[p] === 1'b1 && tslot[p] === 5'h00 && !tseen[p]) begin
          chk(tbyte[p], ex[p], "tx byte");
          tseen[p] = 1'b1;
        end
      end
      if (i == L - 1) begin
        for (int p = 0; p < 4; p++) begin
          for (int j = 0; j < L; j++) begin
            map(m, j, f, s, b);
            if (m == 0)
              f = p;
            // Ports that carry no stream keep their lines idle at 1
            ed[p][j] = (m == 0 ? p == 3 : p != 0) ? 1'b1 : (s == 1 ? lat[f].sig[b] : lat[f].data[b]);
            es[p][j] = (m == 0 ? p == 3 : p != 0) || m == 2 ? 1'b1 : lat[f].sig[b];
          end
          chk(gd[p], ed[p], "rx data");
          chk(gs[p], es[p], "rx signaling");
        end
      end
    end
    chk(tseen, 4'hf, "tx slots seen");
    chk(tk, m == 0 ? 4'h7 : 4'hf, "rx takes");
    go <= 1'b0;
  endtask

  // The framer side hands over a fresh byte once the port has taken the last one
  always @(posedge hwy_clk) begin
    for (int f = 0; f < 4; f++) begin
      if (take[f] === 1'b1) begin
        lf2 = nxt(lf2);
        rbyte[f] <= lf2;
      end
    end
  end

  initial begin
    #4000000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end

  initial begin
    int ro;
    int to;
    int n;
    logic [7:0] r;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int j = 0; j < 7; j++)
      rchk(rg[j], 32'h0);
    for (int j = 0; j < 7; j++) begin
      rnd(r);
      wreg(rg[j], r);
      bus(1'b1, rg[j], ~r, 4'he);
      rchk(rg[j], {24'h0, r});
    end
    bus(1'b1, 6'h30, 8'h5a, 4'hf);
    rchk(6'h30, 32'h0);
    wreg(`SHW_IDX_STATUS, 8'hff);
    for (int m = 0; m < 3; m++) begin
      rnd(r);
      ro = m == 1 ? 0 : int'(r[3:0]);
      rnd(r);
      to = m == 2 ? 15 : int'(r[3:0]);
      wreg(`SHW_IDX_GLOBAL_MODE, mv[m]);
      wreg(`SHW_IDX_RX_OFFSET, 8'(ro));
      wreg(`SHW_IDX_TX_OFFSET, 8'(to));
      for (int p = 0; p < 4; p++)
        wreg(`SHW_IDX_RX_CTRL0 + 6'(p), m == 0 && p == 3 ? 8'h00 : 8'h08);
      repeat (20) @(posedge clk);
      rchk(`SHW_IDX_STATUS, {27'h0, 1'b0, ms[m]});
      for (int p = 0; p < 4; p++) begin
        for (int j = 0; j < 8; j++) begin
          rnd(r);
          sd[p][j * 8 +: 8] = r;
          rnd(r);
          ss[p][j * 8 +: 8] = r;
        end
      end
      width = 2'(m == 1 ? 2 + lfsr[0] : m == 2 ? 1 + lfsr[0] : 1);
      lag = 8'(to);
      run(m, ro);
    end
    wreg(`SHW_IDX_GLOBAL_MODE, 8'h06);
    repeat (20) @(posedge clk);
    rchk(`SHW_IDX_STATUS, 32'h1);
    pin <= 1'b1;
    wreg(`SHW_IDX_GLOBAL_MODE, 8'h00);
    repeat (20) @(posedge clk);
    rchk(`SHW_IDX_STATUS, 32'h11);
    repeat (30) begin
      @(posedge hwy_clk);
      chk({rxd, rxs, take}, 12'hff0, "highway off");
    end
    pin <= 1'b0;
    wreg(`SHW_IDX_RX_CTRL0, 8'h28);
    n = 0;
    do begin
      @(posedge hwy_clk);
      n++;
    end while (!(soe[0] === 1'b1 && so[0] === 1'b1) && n < 600);
    chk(n < 600, 1, "internal sync");
    wrap_up;
  end
endmodule
